// ==== pkg/scseq_pkg.sv ====
// constants and carrier types for the self-calibration sequencer
package scseq_pkg;
   // axi4-lite register offsets
   localparam logic [7:0] SCSEQ_CTRL_OFS   = 8'h00; // mode, trim skip, range
   localparam logic [7:0] SCSEQ_STATUS_OFS = 8'h04; // state readback
   // control field positions
   localparam int SCSEQ_EXT_BIT  = 0;
   localparam int SCSEQ_SKIP_BIT = 1;
   localparam int SCSEQ_FSR_LSB  = 8;
   localparam int SCSEQ_FSR_W    = 10;
   // range codes in millivolt peak-to-peak
   localparam logic [9:0] SCSEQ_FSR_LOW_MV  = 10'h28A; // 650
   localparam logic [9:0] SCSEQ_FSR_HIGH_MV = 10'h366; // 870
   localparam logic [9:0] SCSEQ_FSR_MIN_MV  = 10'h230; // 560
   localparam logic [9:0] SCSEQ_FSR_MAX_MV  = 10'h348; // 840
   localparam logic [9:0] SCSEQ_FSR_RST_MV  = 10'h2BC; // 700
   // trigger qualification count
   localparam int SCSEQ_TRIG_CYCLES = 80;
   // axi responses
   localparam logic [1:0] SCSEQ_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SCSEQ_RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      SCSEQ_ST_DELAY, SCSEQ_ST_IDLE, SCSEQ_ST_ARM, SCSEQ_ST_CORE,
      SCSEQ_ST_TRIM, SCSEQ_ST_PDN
   } scseq_state_e;
   // calibration flags carried together
   typedef struct packed {
      logic active;
      logic trim;
      logic analog_off;
   } scseq_cal_s;
endpackage

// ==== hw/scseq_top.sv ====
// self-calibration sequencer with axi4-lite control registers
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module scseq_top #(
   parameter int LONG_DELAY  = 16777216, // long power-on delay in cycles
   parameter int SHORT_DELAY = 65536,    // short power-on delay in cycles
   parameter int CORE_CYCLES = 1024,     // core calibration length
   parameter int TRIM_CYCLES = 256       // termination trim length
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        cal_trigger,           // on-command trigger pin
   input  wire logic        power_down_pin,        // power-down request pin
   input  wire logic        power_on_delay_select, // high picks long delay in normal mode
   input  wire logic        full_scale_select,     // high picks wide range in normal mode
   output logic             calibration_active,    // high while calibrating
   output logic             term_trim_active,      // termination trim phase
   output logic             analog_power_off,      // analog held down
   output logic             output_data_clock_en,  // output data clock gate
   output logic [9:0]       full_scale_mv          // applied range
);
   //------------------------------------------------------------
   // pin synchronisers
   //------------------------------------------------------------
   logic [2:0] trig_sync_reg;  // three stage trigger chain
   logic [2:0] pd_sync_reg;    // three stage power-down chain
   logic [2:0] fss_sync_reg;   // three stage range select chain
   logic [2:0] dsel_sync_reg;  // three stage delay select chain
   logic       trig_reg;       // filtered trigger level
   logic       pd_reg;         // filtered power-down level
   logic       fss_reg;        // filtered range select level
   logic       dsel_reg;       // filtered delay select level
   // filtered level follows stage three once stage two agrees
   function automatic logic scseq_settle(input logic [2:0] chain, input logic level);
      return (chain[1] == chain[2]) ? chain[2] : level;
   endfunction
   // chains run through reset, so pin levels are valid at release
   always_ff @(posedge aclk)
   begin
      trig_sync_reg <= {trig_sync_reg[1:0], cal_trigger};
      pd_sync_reg   <= {pd_sync_reg[1:0], power_down_pin};
      fss_sync_reg  <= {fss_sync_reg[1:0], full_scale_select};
      dsel_sync_reg <= {dsel_sync_reg[1:0], power_on_delay_select};
   end
   // change accepted once stages two and three agree
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trig_reg <= 1'b0;
         pd_reg   <= 1'b0;
         fss_reg  <= 1'b0;
         dsel_reg <= 1'b0;
      end
      else
      begin
         trig_reg <= scseq_settle(trig_sync_reg, trig_reg);
         pd_reg   <= scseq_settle(pd_sync_reg, pd_reg);
         fss_reg  <= scseq_settle(fss_sync_reg, fss_reg);
         dsel_reg <= scseq_settle(dsel_sync_reg, dsel_reg);
      end
   end

   //------------------------------------------------------------
   // register file
   //------------------------------------------------------------
   logic       ext_mode_reg;   // extended control mode
   logic       skip_trim_reg;  // omit termination trim on command in extended mode
   logic [9:0] fsr_prog_reg;   // programmed range, millivolts
   logic       aw_held_reg;    // write address captured
   logic       w_held_reg;     // write data captured
   logic [7:0] awaddr_reg;     // captured write address
   logic [31:0] wdata_reg;     // captured write data
   logic [3:0] wstrb_reg;      // captured strobes
   scseq_pkg::scseq_state_e state_reg;
   logic        strap_done_reg;
   logic        boot_trig_reg;

   function automatic logic [9:0] scseq_clamp(input logic [9:0] v);
      if (v < scseq_pkg::SCSEQ_FSR_MIN_MV)
         return scseq_pkg::SCSEQ_FSR_MIN_MV;
      if (v > scseq_pkg::SCSEQ_FSR_MAX_MV)
         return scseq_pkg::SCSEQ_FSR_MAX_MV;
      return v;
   endfunction

   // write channel: address and data in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= scseq_pkg::SCSEQ_RESP_OKAY;
         ext_mode_reg  <= 1'b0;
         skip_trim_reg <= 1'b0;
         fsr_prog_reg  <= scseq_pkg::SCSEQ_FSR_RST_MV;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         // both halves present: commit and answer
         if (aw_held_reg && w_held_reg && !s_axi_bvalid)
         begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awaddr_reg == scseq_pkg::SCSEQ_CTRL_OFS)
            begin
               s_axi_bresp <= scseq_pkg::SCSEQ_RESP_OKAY;
               if (wstrb_reg[0])
               begin
                  ext_mode_reg  <= wdata_reg[scseq_pkg::SCSEQ_EXT_BIT];
                  skip_trim_reg <= wdata_reg[scseq_pkg::SCSEQ_SKIP_BIT];
               end
               if (wstrb_reg[1])
                  fsr_prog_reg <= scseq_clamp(
                     wdata_reg[scseq_pkg::SCSEQ_FSR_LSB +: scseq_pkg::SCSEQ_FSR_W]);
            end
            else if (awaddr_reg == scseq_pkg::SCSEQ_STATUS_OFS)
               s_axi_bresp <= scseq_pkg::SCSEQ_RESP_OKAY;
            else
               s_axi_bresp <= scseq_pkg::SCSEQ_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ready while each half is empty
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // read channel, one cycle after address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= scseq_pkg::SCSEQ_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= scseq_pkg::SCSEQ_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr == scseq_pkg::SCSEQ_CTRL_OFS)
            begin
               s_axi_rdata[scseq_pkg::SCSEQ_EXT_BIT]  <= ext_mode_reg;
               s_axi_rdata[scseq_pkg::SCSEQ_SKIP_BIT] <= skip_trim_reg;
               s_axi_rdata[scseq_pkg::SCSEQ_FSR_LSB +: scseq_pkg::SCSEQ_FSR_W] <= fsr_prog_reg;
            end
            else if (s_axi_araddr == scseq_pkg::SCSEQ_STATUS_OFS)
               s_axi_rdata <= {27'h0, pd_reg, calibration_active, state_reg};
            else
               s_axi_rresp <= scseq_pkg::SCSEQ_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // trigger qualifier
   //------------------------------------------------------------
   logic [7:0] low_cnt_reg;   // cycles trigger seen low
   logic [7:0] high_cnt_reg;  // cycles high after qualified low
   logic       low_ok_reg;    // low period long enough
   logic       cmd_go;        // qualified request
   assign cmd_go = low_ok_reg && trig_reg
                   && (high_cnt_reg == 8'(scseq_pkg::SCSEQ_TRIG_CYCLES - 1));
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         low_cnt_reg  <= 8'h00;
         high_cnt_reg <= 8'h00;
         low_ok_reg   <= 1'b0;
      end
      else if (pd_reg || calibration_active)
      begin
         // trigger activity discarded while powered down or calibrating
         low_cnt_reg  <= 8'h00;
         high_cnt_reg <= 8'h00;
         low_ok_reg   <= 1'b0;
      end
      else if (!trig_reg)
      begin
         high_cnt_reg <= 8'h00;
         // the 80th low sample qualifies, so exactly 80 cycles suffice
         if (low_cnt_reg != 8'(scseq_pkg::SCSEQ_TRIG_CYCLES - 1))
            low_cnt_reg <= low_cnt_reg + 8'h01;
         else
            low_ok_reg <= 1'b1;
      end
      else
      begin
         low_cnt_reg <= 8'h00;
         if (!low_ok_reg)
            high_cnt_reg <= 8'h00;                         // short pulse ignored
         else if (cmd_go)
         begin
            low_ok_reg   <= 1'b0;
            high_cnt_reg <= 8'h00;
         end
         else
            high_cnt_reg <= high_cnt_reg + 8'h01;
      end
   end

   //------------------------------------------------------------
   // calibration sequencer
   //------------------------------------------------------------
   logic [31:0] cnt_reg;       // delay and phase counter
   logic        with_trim_reg; // current run includes trim
   logic [31:0] delay_len;
   // long only in normal mode with select high
   assign delay_len = (dsel_reg && !ext_mode_reg) ?
                      32'(LONG_DELAY) : 32'(SHORT_DELAY);
   // every step counts aclk edges, so a late clock only shifts it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg      <= scseq_pkg::SCSEQ_ST_DELAY;
         cnt_reg        <= 32'h0000_0000;
         with_trim_reg  <= 1'b1;
         strap_done_reg <= 1'b0;
         boot_trig_reg  <= 1'b0;
      end
      else
      begin
         strap_done_reg <= 1'b1;
         unique case (state_reg)
            scseq_pkg::SCSEQ_ST_DELAY:
            begin
               // trigger high at power-up skips this run
               if (!strap_done_reg)
                  boot_trig_reg <= trig_sync_reg[2];
               if (strap_done_reg && boot_trig_reg)
                  state_reg <= scseq_pkg::SCSEQ_ST_IDLE;
               else if (pd_reg || !strap_done_reg)
                  cnt_reg <= cnt_reg;                      // also until pins settle
               else if (cnt_reg >= delay_len - 32'h1)
               begin
                  cnt_reg       <= 32'h0000_0000;
                  with_trim_reg <= 1'b1;
                  state_reg     <= scseq_pkg::SCSEQ_ST_CORE;
               end
               else
                  cnt_reg <= cnt_reg + 32'h1;
            end
            scseq_pkg::SCSEQ_ST_IDLE, scseq_pkg::SCSEQ_ST_ARM:
            begin
               if (pd_reg)
                  state_reg <= scseq_pkg::SCSEQ_ST_PDN;
               else if (cmd_go)
               begin
                  cnt_reg       <= 32'h0000_0000;
                  with_trim_reg <= !(ext_mode_reg && skip_trim_reg);
                  state_reg     <= scseq_pkg::SCSEQ_ST_CORE;
               end
            end
            scseq_pkg::SCSEQ_ST_CORE:
            begin
               // power-down waits for the run to end
               if (cnt_reg == 32'(CORE_CYCLES - 1))
               begin
                  cnt_reg   <= 32'h0000_0000;
                  state_reg <= with_trim_reg ? scseq_pkg::SCSEQ_ST_TRIM
                                             : scseq_pkg::SCSEQ_ST_IDLE;
               end
               else
                  cnt_reg <= cnt_reg + 32'h1;
            end
            scseq_pkg::SCSEQ_ST_TRIM:
            begin
               if (cnt_reg == 32'(TRIM_CYCLES - 1))
               begin
                  cnt_reg   <= 32'h0000_0000;
                  state_reg <= scseq_pkg::SCSEQ_ST_IDLE;
               end
               else
                  cnt_reg <= cnt_reg + 32'h1;
            end
            scseq_pkg::SCSEQ_ST_PDN:
            begin
               if (!pd_reg)
                  state_reg <= scseq_pkg::SCSEQ_ST_IDLE;
            end
            default:
               state_reg <= scseq_pkg::SCSEQ_ST_IDLE;
         endcase
      end
   end

   //------------------------------------------------------------
   // registered outputs
   //------------------------------------------------------------
   scseq_pkg::scseq_cal_s cal_next;
   always_comb
   begin
      cal_next.active     = (state_reg == scseq_pkg::SCSEQ_ST_CORE)
                            || (state_reg == scseq_pkg::SCSEQ_ST_TRIM);
      cal_next.trim       = (state_reg == scseq_pkg::SCSEQ_ST_TRIM);
      // held down until clocked reset has run, and again while in power-down
      cal_next.analog_off = !strap_done_reg || (state_reg == scseq_pkg::SCSEQ_ST_PDN);
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         calibration_active   <= 1'b0;
         term_trim_active     <= 1'b0;
         analog_power_off     <= 1'b1;
         output_data_clock_en <= 1'b0;
         full_scale_mv        <= scseq_pkg::SCSEQ_FSR_LOW_MV;
      end
      else
      begin
         calibration_active   <= cal_next.active;
         term_trim_active     <= cal_next.trim;
         analog_power_off     <= cal_next.analog_off;
         output_data_clock_en <= !cal_next.trim && !cal_next.analog_off;
         // pin picks range in normal mode
         full_scale_mv <= ext_mode_reg ? fsr_prog_reg :
                          (fss_reg ? scseq_pkg::SCSEQ_FSR_HIGH_MV
                                             : scseq_pkg::SCSEQ_FSR_LOW_MV);
      end
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence go_s;
      cmd_go && !pd_reg && (state_reg == scseq_pkg::SCSEQ_ST_IDLE);
   endsequence
   cmd_start_a: assert property (go_s |=> ##1 calibration_active)
      else $error("command did not start calibration");
   active_state_a: assert property (calibration_active ==
      $past(state_reg == scseq_pkg::SCSEQ_ST_CORE || state_reg == scseq_pkg::SCSEQ_ST_TRIM))
      else $error("calibration active mismatch");
   pd_hold_a: assert property ((state_reg == scseq_pkg::SCSEQ_ST_DELAY) && pd_reg
      && strap_done_reg && !boot_trig_reg |=> $stable(cnt_reg))
      else $error("delay counted during power down");
   pd_ignore_a: assert property (pd_reg |-> !cmd_go)
      else $error("trigger accepted while powered down");
   pd_finish_a: assert property ((state_reg == scseq_pkg::SCSEQ_ST_CORE) && pd_reg
      |=> state_reg != scseq_pkg::SCSEQ_ST_PDN)
      else $error("calibration cut by power down");
   skip_trim_a: assert property ((go_s and (ext_mode_reg && skip_trim_reg))
      |=> !with_trim_reg)
      else $error("trim not skipped");
   short_delay_a: assert property (ext_mode_reg |-> delay_len == 32'(SHORT_DELAY))
      else $error("extended mode used long delay");
   fsr_pin_a: assert property (!ext_mode_reg && fss_reg
      |=> full_scale_mv == scseq_pkg::SCSEQ_FSR_HIGH_MV)
      else $error("range not applied");
   boot_trim_a: assert property ((state_reg == scseq_pkg::SCSEQ_ST_DELAY)
      ##1 (state_reg == scseq_pkg::SCSEQ_ST_CORE) |-> with_trim_reg)
      else $error("power-on run lacks trim");
endmodule

// ==== sim/scseq_ctl_model.sv ====
// controller model driving the calibration and power-down pins
`timescale 1ns/1ns
module scseq_ctl_model (
   input  wire logic aclk,
   input  wire logic calibration_active,
   output logic      cal_trigger,
   output logic      power_down_pin
);
   // ----------------------------------------
   // pin drive
   // ----------------------------------------
   // driven levels with no pull, defined from time zero
   initial
   begin
      cal_trigger = 1'b0;
      power_down_pin = 1'b0;
   end
   // set both pin levels just after an edge
   task automatic set_pins(input logic t, input logic p);
      cal_trigger <= t;
      power_down_pin <= p;
   endtask
   // low then high; short counts probe the noise filter
   task automatic request(input int lo, input int hi);
      cal_trigger <= 1'b0;
      repeat (lo) @(posedge aclk);
      cal_trigger <= 1'b1;
      repeat (hi) @(posedge aclk);
   endtask
   // follow the active flag until the run ends, bounded
   task automatic wait_idle(input int lim, output int n);
      n = 0;
      while (calibration_active === 1'b1 && n < lim)
      begin
         @(posedge aclk);
         n++;
      end
   endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking testbench for the self-calibration sequencer
`timescale 1ns/1ns
module testbench;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   localparam int LONG  = 40; // shortened long delay
   localparam int SHORT = 20; // shortened short delay
   localparam int CORE  = 16; // shortened core phase
   localparam int TRIM  = 8;  // shortened trim phase
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, dsel = 1'b0, fss = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        trig, pd, cal_act, trim_act, an_off, ck_en;
   logic [9:0]  fs_mv;
   int          failures = 0, samples_checked = 0;
   scseq_top #(.LONG_DELAY(LONG), .SHORT_DELAY(SHORT), .CORE_CYCLES(CORE),
      .TRIM_CYCLES(TRIM)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cal_trigger(trig), .power_down_pin(pd), .power_on_delay_select(dsel),
      .full_scale_select(fss), .calibration_active(cal_act), .term_trim_active(trim_act),
      .analog_power_off(an_off), .output_data_clock_en(ck_en), .full_scale_mv(fs_mv));
   scseq_ctl_model ctl (.aclk(aclk), .calibration_active(cal_act),
      .cal_trigger(trig), .power_down_pin(pd));
   // free-running clock, 50 ns period
   initial
   begin
      forever #25 aclk = ~aclk;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic conclude();
      if (failures == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // control word: ext mode, trim skip, range in mV
   function automatic logic [31:0] cw(input int e, input int s, input logic [9:0] mv);
      return {14'h0, mv, 6'h0, 1'(s), 1'(e)};
   endfunction
   // write: each channel released when taken, bready held until bvalid
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", {1'b1, er}, {bvalid, bresp});
      // let an edge pass so a following call never re-raises bready at once
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rresp", {1'b1, er}, {rvalid, rresp});
      chk("rdata", ed, rdata);
      // let an edge pass so a following call never re-raises rready at once
      @(posedge aclk);
   endtask
   // reset with given pin levels; analog held off and idle meanwhile
   task automatic do_reset(input logic t, input logic p, input logic d);
      aresetn <= 1'b0;
      dsel <= d;
      ctl.set_pins(t, p);
      repeat (5) @(posedge aclk);
      chk("reset_flags", 32'h1, {cal_act, an_off});
      aresetn <= 1'b1;
   endtask
   task automatic wait_rise(input int lim, output int n);
      n = 0;
      while (cal_act !== 1'b1 && n < lim)
      begin
         @(posedge aclk);
         n++;
      end
   endtask
   // count active, trim and gated-clock cycles of one run
   task automatic run(output int a, output int t, output int c);
      a = 0;
      t = 0;
      c = 0;
      while (cal_act === 1'b1 && a < 500)
      begin
         a++;
         t += int'(trim_act === 1'b1);
         c += int'(ck_en !== 1'b1);
         @(posedge aclk);
      end
   endtask
   task automatic quiet(input int cyc, input string name);
      logic seen;
      seen = 1'b0;
      repeat (cyc)
      begin
         @(posedge aclk);
         seen = seen | cal_act;
      end
      chk(name, 32'h0, seen);
   endtask
   // commanded run: no start before the 80th high cycle, then soon after
   task automatic cmd_run(input int ea, input int et);
      int n, a, t, c;
      ctl.request(80, 80);
      chk("early_start", 32'h0, cal_act);
      wait_rise(14, n);
      chk("late_start", 32'h1, n < 14);
      run(a, t, c);
      chk("run_len", ea, a);
      chk("trim_len", et, t);
      chk("clk_off", et, c);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_basic();
      do_reset(1'b0, 1'b0, 1'b0);
      axi_rd(scseq_pkg::SCSEQ_CTRL_OFS, cw(0, 0, scseq_pkg::SCSEQ_FSR_RST_MV), 2'h0);
      axi_rd(8'h08, 32'h0, scseq_pkg::SCSEQ_RESP_SLVERR);
      axi_wr(8'h0C, 32'h3, scseq_pkg::SCSEQ_RESP_SLVERR);
      axi_rd(scseq_pkg::SCSEQ_CTRL_OFS, cw(0, 0, scseq_pkg::SCSEQ_FSR_RST_MV), 2'h0);
      // pin passes three flops and the agreement filter before it applies
      fss <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("range_high", scseq_pkg::SCSEQ_FSR_HIGH_MV, fs_mv);
      fss <= 1'b0;
      repeat (6) @(posedge aclk);
      chk("range_low", scseq_pkg::SCSEQ_FSR_LOW_MV, fs_mv);
      axi_wr(scseq_pkg::SCSEQ_CTRL_OFS, cw(1, 0, 10'h258), 2'h0);
      repeat (3) @(posedge aclk);
      chk("range_prog", 32'h258, fs_mv);
      axi_wr(scseq_pkg::SCSEQ_CTRL_OFS, cw(1, 0, 10'h384), 2'h0);
      repeat (3) @(posedge aclk);
      chk("range_max", scseq_pkg::SCSEQ_FSR_MAX_MV, fs_mv);
      axi_wr(scseq_pkg::SCSEQ_CTRL_OFS, cw(1, 0, 10'h1F4), 2'h0);
      repeat (3) @(posedge aclk);
      chk("range_min", scseq_pkg::SCSEQ_FSR_MIN_MV, fs_mv);
   endtask
   task automatic t_power_on(input logic d, input int dly);
      int n, a, t, c;
      do_reset(1'b0, 1'b0, d);
      wait_rise(dly + 20, n);
      chk("delay_window", 32'h1, n >= dly && n <= dly + 6);
      run(a, t, c);
      chk("run_len", CORE + TRIM, a);
      chk("trim_len", TRIM, t);
   endtask
   task automatic t_ext();
      int n;
      do_reset(1'b0, 1'b0, 1'b1);
      axi_wr(scseq_pkg::SCSEQ_CTRL_OFS, cw(1, 0, scseq_pkg::SCSEQ_FSR_RST_MV), 2'h0);
      wait_rise(LONG + 20, n);
      chk("short_used", 32'h1, n <= SHORT + 10);
      ctl.wait_idle(100, n);
      chk("idle_after", CORE + TRIM, n);
      axi_wr(scseq_pkg::SCSEQ_CTRL_OFS, cw(1, 1, scseq_pkg::SCSEQ_FSR_RST_MV), 2'h0);
      cmd_run(CORE, 0);
      axi_wr(scseq_pkg::SCSEQ_CTRL_OFS, cw(1, 0, scseq_pkg::SCSEQ_FSR_RST_MV), 2'h0);
      cmd_run(CORE + TRIM, TRIM);
   endtask
   task automatic t_trig();
      do_reset(1'b1, 1'b0, 1'b0);
      quiet(LONG + CORE + TRIM + 20, "skip_power_on");
      ctl.request(40, 80);
      ctl.request(80, 40);
      ctl.set_pins(1'b0, 1'b0);
      quiet(100, "short_pulse");
      cmd_run(CORE + TRIM, TRIM);
   endtask
   task automatic t_pd();
      int n, a, t, c;
      do_reset(1'b0, 1'b1, 1'b0);
      quiet(60, "pd_hold");
      ctl.set_pins(1'b0, 1'b0);
      wait_rise(SHORT + 20, n);
      chk("pd_release", 32'h1, n >= SHORT && n <= SHORT + 10);
      ctl.set_pins(1'b0, 1'b1);
      run(a, t, c);
      chk("pd_mid_run", CORE + TRIM, a);
      repeat (10) @(posedge aclk);
      chk("pd_entered", 32'h1, an_off);
      ctl.request(80, 80);
      quiet(100, "pd_ignores");
      ctl.set_pins(1'b0, 1'b0);
      repeat (10) @(posedge aclk);
      chk("pd_left", 32'h0, an_off);
   endtask
   // ----------------------------------------
   // sequence and watchdog
   // ----------------------------------------
   initial
   begin
      @(posedge aclk);
      t_basic();
      t_power_on(1'b0, SHORT);
      t_power_on(1'b1, LONG);
      t_ext();
      t_trig();
      t_pd();
      conclude();
   end
   initial
   begin
      repeat (20000) @(posedge aclk);
      failures++;
      conclude();
   end
endmodule
